//--- bench/dcz_checker.sv
/* Port-level assertions for the DAC control block top.
 * Assumes it is bound into dcz_top, whose ports of the same names it watches. */
`default_nettype none
module dcz_checker (
    // System.
    input wire logic CLK,
    input wire logic RST_B,
    // Register bus.
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Pins and results.
    input wire logic INTERFACE_SELECT_PIN,
    input wire logic INTERFACE_I2C,
    input wire logic FRAME_CLOCK,
    input wire logic [1:0] OVERSAMPLE_RATE,
    input wire logic ZERO_FLAG_SECOND
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    property p_b_after; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID; endproperty
    a_b_after: assert property (p_b_after) else $error("write response late");
    property p_b_ready; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_b_ready: assert property (p_b_ready) else $error("write ready during response");
    property p_ready_back; S_AXI_BVALID && S_AXI_BREADY |=> S_AXI_AWREADY && S_AXI_WREADY && !S_AXI_BVALID; endproperty
    a_ready_back: assert property (p_ready_back) else $error("write channel not reopened");
    property p_r_after; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
    a_r_after: assert property (p_r_after) else $error("read answer late");
    property p_r_back; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY; endproperty
    a_r_back: assert property (p_r_back) else $error("read channel not reopened");
    property p_i2c_mode; $stable(INTERFACE_SELECT_PIN) [*5] |-> INTERFACE_I2C == INTERFACE_SELECT_PIN; endproperty
    a_i2c_mode: assert property (p_i2c_mode) else $error("interface mode does not follow pin");
    property p_osr_reset; $rose(RST_B) |-> OVERSAMPLE_RATE == 2'h3; endproperty
    a_osr_reset: assert property (p_osr_reset) else $error("rate code wrong after reset");
    property p_osr_steady; $stable(FRAME_CLOCK) [*8] |-> $stable(OVERSAMPLE_RATE); endproperty
    a_osr_steady: assert property (p_osr_steady) else $error("rate code moved between frames");
    cp_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    cp_flag: cover property ($rose(ZERO_FLAG_SECOND));
    cp_osr: cover property ($changed(OVERSAMPLE_RATE));
endmodule : dcz_checker
`default_nettype wire

//--- bench/dcz_host_model.sv
/* Behavioural host that writes control words over the three-wire port.
 * Assumes the caller waits for each send to return before the next. */
`default_nettype none
module dcz_host_model (
    // Three-wire control pins.
    output logic select_n,
    output logic shift_clock,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        select_n = 1'b1;
        shift_clock = 1'b0;
        serial_in = 1'b0;
    end
    // Delays, not the system clock, pace the link; every pin change lands 13 ns after a rising clock edge.
    task automatic send(input logic [15:0] w, input int n);
        #13;
        select_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            serial_in = w[i];
            #200;
            shift_clock = 1'b1;
            #200;
            shift_clock = 1'b0;
        end
        #200;
        select_n = 1'b1;
        serial_in = ~serial_in;
        #387;
    endtask : send
endmodule : dcz_host_model
`default_nettype wire

//--- bench/tb_top.sv
/* Self-checking bench of the DAC control block: bus master, serial host and audio source.
 * Assumes the design package, interface and modules are compiled before it. */
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dcz_pkg::*;
    logic CLK = 1'b0, RST_B = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, INTERFACE_SELECT_PIN = 1'b0, I2C_WR_STROBE = 1'b0;
    logic FRAME_CLOCK = 1'b0, AUDIO_BIT_CLOCK = 1'b0, AUDIO_LANE_1 = 1'b0, AUDIO_LANE_2 = 1'b0;
    logic AUDIO_LANE_3 = 1'b0, AUDIO_LANE_4 = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, I2C_WR_DATA = 8'h00, I2C_RD_DATA, d;
    logic [6:0] I2C_WR_INDEX = 7'h00, I2C_RD_INDEX = 7'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdat;
    logic [3:0] S_AXI_WSTRB = 4'hf, ones = 4'h0;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, OVERSAMPLE_RATE, resp;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, INTERFACE_I2C, IRQ;
    logic CONTROL_SELECT_N, CONTROL_SHIFT_CLOCK, CONTROL_SERIAL_IN, ZERO_FLAG_FIRST, ZERO_FLAG_SECOND;
    int seed = 32'h51a6, n_fail = 0, n_checks = 0, fp = 32, frames = 0;
    int rtab[7] = '{128, 192, 256, 384, 512, 768, 1152};
    dcz_top i_dcz_top (.*);
    dcz_host_model i_dcz_host_model (.select_n(CONTROL_SELECT_N), .shift_clock(CONTROL_SHIFT_CLOCK),
        .serial_in(CONTROL_SERIAL_IN));
    initial forever #25 CLK = ~CLK;
    // Audio source: frame of fp clocks, bit clock of four clocks, lanes change while it is low.
    initial begin
        int p;
        forever begin
            p = fp;
            for (int i = 0; i < p; i++) begin
                @(posedge CLK);
                FRAME_CLOCK <= (i < p / 2);
                AUDIO_BIT_CLOCK <= i[1];
                if (i % 4 == 0) {AUDIO_LANE_4, AUDIO_LANE_3, AUDIO_LANE_2, AUDIO_LANE_1} <= ones;
            end
            frames++;
        end
    end
    function automatic logic [15:0] mk(input logic [6:0] i, input logic [7:0] v);
        return {1'b0, i, v};
    endfunction : mk
    function automatic logic [1:0] osr_of(input int r);
        if (r >= 512) return OSR_64X;
        return (r >= 256) ? OSR_32X : OSR_16X;
    endfunction : osr_of
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= v;
        S_AXI_WSTRB <= {3'($random(seed)), 1'b1};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        forever begin
            @(posedge CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID) begin
                resp = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
                break;
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        forever begin
            @(posedge CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID) begin
                rdat = S_AXI_RDATA;
                resp = S_AXI_RRESP;
                S_AXI_RREADY <= 1'b0;
                break;
            end
        end
    endtask : rd
    task automatic wf(input int n);
        repeat (n) @(frames);
    endtask : wf
    task automatic summarize();
        $display("Checks %0d, errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        #4000000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        `CHK("osr reset", 2'h3, OVERSAMPLE_RATE)
        rd(8'h28);
        `CHK("polarity reset", 8'h00, rdat[7:0])
        wr(ADDR_IRQ_ENABLE, 32'h1);
        `CHK("write okay", RESP_OKAY, resp)
        wr(ADDR_IRQ_CLEAR, 32'h1f);
        d = (8'($random(seed)) & 8'h7e) | 8'h01;
        i_dcz_host_model.send(mk(7'd5, d), 16);
        `CHK("irq word", 1'b1, IRQ)
        rd(8'h14);
        `CHK("reg5", d, rdat[7:0])
        wr(ADDR_IRQ_CLEAR, 32'h1);
        wr(ADDR_IRQ_ENABLE, 32'h0);
        `CHK("irq cleared", 1'b0, IRQ)
        i_dcz_host_model.send(mk(7'd20, ~d), 16);
        `CHK("irq masked", 1'b0, IRQ)
        rd(ADDR_IRQ_STATUS);
        `CHK("word accepted", 1'b1, rdat[IRQ_WORD])
        rd(8'h10);
        `CHK("reg4", 8'h00, rdat[7:0])
        i_dcz_host_model.send(mk(7'd6, d), 15);
        rd(8'h18);
        `CHK("short frame", 8'h00, rdat[7:0])
        i_dcz_host_model.send({1'b1, 7'd7, d}, 16);
        rd(8'h1c);
        `CHK("not a write", 8'h00, rdat[7:0])
        rd(8'h80);
        `CHK("unmapped", RESP_SLVERR, resp)
        wr(8'h80, 32'h0);
        `CHK("unmapped write", RESP_SLVERR, resp)
        INTERFACE_SELECT_PIN <= 1'b1;
        i_dcz_host_model.send(mk(7'd8, d), 16);
        `CHK("i2c mode", 1'b1, INTERFACE_I2C)
        rd(8'h20);
        `CHK("serial ignored", 8'h00, rdat[7:0])
        I2C_WR_INDEX <= 7'd9;
        I2C_WR_DATA <= d;
        I2C_RD_INDEX <= 7'd9;
        I2C_WR_STROBE <= 1'b1;
        @(posedge CLK);
        I2C_WR_STROBE <= 1'b0;
        rd(8'h24);
        `CHK("reg9 bus", d, rdat[7:0])
        `CHK("reg9 side", d, I2C_RD_DATA)
        INTERFACE_SELECT_PIN <= 1'b0;
        foreach (rtab[k]) begin
            fp = rtab[k];
            wf(4);
            `CHK("osr", osr_of(fp), OVERSAMPLE_RATE)
        end
        fp = 32;
        ones <= 4'hf;
        i_dcz_host_model.send(mk(7'd13, 8'h03), 16);
        wf(2);
        ones <= 4'h0;
        wf(1024);
        `CHK("flags early", 2'b00, {ZERO_FLAG_FIRST, ZERO_FLAG_SECOND})
        wf(1);
        `CHK("flags set", 2'b11, {ZERO_FLAG_FIRST, ZERO_FLAG_SECOND})
        ones <= 4'h4;
        wf(1);
        ones <= 4'h0;
        `CHK("lane3 one", 2'b10, {ZERO_FLAG_FIRST, ZERO_FLAG_SECOND})
        i_dcz_host_model.send(mk(7'd10, 8'h01), 16);
        `CHK("inverted", 2'b01, {ZERO_FLAG_FIRST, ZERO_FLAG_SECOND})
        summarize();
    end
endmodule : tb_top
bind dcz_top dcz_checker i_dcz_checker (.*);
`default_nettype wire

//--- hdl/dcz_pkg.sv
/*
 * Shared constants and types of the DAC control port and zero-flag block.
 * Assumes a single system clock; every pin input is synchronised before use.
 */
`default_nettype none
package dcz_pkg;
    localparam int IDX_W = 7;
    localparam logic [4:0] WORD_BITS_COUNT = 5'h10;
    localparam logic [4:0] BIT_COUNT_MAX = 5'h1f;
    localparam logic [10:0] ZERO_RUN_LIMIT = 11'h400;
    // Mode register indices and fields.
    localparam logic [3:0] IDX_RESERVED_A = 4'h0;
    localparam logic [3:0] IDX_RESERVED_B = 4'hb;
    localparam logic [3:0] IDX_RESERVED_C = 4'hf;
    localparam logic [3:0] IDX_POLARITY = 4'ha;
    localparam logic [3:0] IDX_ZERO_GROUP = 4'hd;
    localparam int POLARITY_BIT = 0;
    localparam int ZERO_GROUP_LSB = 0;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Register bus map.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_STATUS = 8'h40;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h44;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h48;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h4c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ST_OSR_LSB = 0;
    localparam int ST_I2C = 2;
    localparam int ST_ZF_FIRST = 3;
    localparam int ST_ZF_SECOND = 4;
    // Interrupt status bits.
    localparam int IRQ_W = 5;
    localparam int IRQ_WORD = 0;
    localparam int IRQ_FRAME_ERR = 1;
    localparam int IRQ_ZERO_FIRST = 2;
    localparam int IRQ_ZERO_SECOND = 3;
    localparam int IRQ_RATIO = 4;
    localparam logic [4:0] IRQ_RESET = 5'h00;
    // Synchronised pin vector positions.
    localparam int PIN_W = 10;
    localparam int PIN_IFSEL = 0;
    localparam int PIN_SELN = 1;
    localparam int PIN_SCLK = 2;
    localparam int PIN_SDI = 3;
    localparam int PIN_FRAME = 4;
    localparam int PIN_BCK = 5;
    localparam int PIN_LANE0 = 6;
    localparam logic [9:0] PIN_RESET = 10'h002;
    // System clocks per frame for each supported ratio.
    localparam logic [11:0] RATIO_128 = 12'h080;
    localparam logic [11:0] RATIO_192 = 12'h0c0;
    localparam logic [11:0] RATIO_256 = 12'h100;
    localparam logic [11:0] RATIO_384 = 12'h180;
    localparam logic [11:0] RATIO_512 = 12'h200;
    localparam logic [11:0] RATIO_768 = 12'h300;
    localparam logic [11:0] RATIO_1152 = 12'h480;
    localparam logic [11:0] RATIO_TOL = 12'h002;
    localparam logic [11:0] RATIO_COUNT_MAX = 12'hfff;
    // Channel masks per grouping A..D; bit 2k is lane k+1 left, 2k+1 its right.
    localparam logic [3:0][7:0] FIRST_MASKS = {8'h03, 8'hc0, 8'h00, 8'h01};
    localparam logic [3:0][7:0] SECOND_MASKS = {8'hfc, 8'h3f, 8'hff, 8'h02};
    typedef enum logic [1:0] {OSR_16X, OSR_32X, OSR_64X, OSR_NONE} dcz_osr_type;
endpackage : dcz_pkg
`default_nettype wire

//--- hdl/dcz_serial_rx.sv
/*
 * Three-wire control word receiver.
 * Assumes select, shift edge and data bit arrive already synchronised.
 */
`default_nettype none
module dcz_serial_rx (
    // System.
    input wire logic clk,
    input wire logic rst_b,
    // Synchronised pins.
    input wire logic enable,
    input wire logic select_n,
    input wire logic shift_rise,
    input wire logic serial_bit,
    // Received word.
    dcz_word_if.rx word
);
    import dcz_pkg::*;
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0] count;
        logic opened;
        logic sel_prev;
        logic valid;
        logic [IDX_W-1:0] index;
        logic [7:0] data;
        logic frame_error;
    } dcz_rx_type;
    dcz_rx_type r_r, r_nxt;
    always_comb begin
        r_nxt = r_r;
        r_nxt.valid = 1'b0;
        r_nxt.frame_error = 1'b0;
        r_nxt.sel_prev = select_n;
        if (!enable) begin
            r_nxt.opened = 1'b0;
            r_nxt.count = 5'h00;
        end else if (!select_n) begin
            r_nxt.opened = 1'b1;
            if (r_r.sel_prev) begin
                r_nxt.count = 5'h00;
            end
            if (shift_rise) begin
                r_nxt.shift = {r_r.shift[14:0], serial_bit};
                if (r_nxt.count != BIT_COUNT_MAX) begin
                    r_nxt.count = r_nxt.count + 5'h01;
                end
            end
        end else if (r_r.opened) begin
            r_nxt.opened = 1'b0;
            // A short, long or non-write word is dropped and reported.
            if (r_r.count == WORD_BITS_COUNT && !r_r.shift[15]) begin
                r_nxt.valid = 1'b1;
                r_nxt.index = r_r.shift[14:8];
                r_nxt.data = r_r.shift[7:0];
            end else begin
                r_nxt.frame_error = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r_r <= '{shift: 16'h0000, count: 5'h00, opened: 1'b0, sel_prev: 1'b1, valid: 1'b0,
                     index: 7'h00, data: 8'h00, frame_error: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end
    assign word.valid = r_r.valid;
    assign word.index = r_r.index;
    assign word.data = r_r.data;
    assign word.frame_error = r_r.frame_error;
endmodule : dcz_serial_rx
`default_nettype wire

//--- hdl/dcz_top.sv
/*
 * Control port, mode registers, clock ratio detection and zero flags of the DAC.
 * Assumes an AXI4-Lite master on CLK and pins from outside the clock domain.
 */
// The AXI4-Lite slave port and the address map are this design's own decisions.
`default_nettype none
module dcz_top (
    // System.
    input wire logic CLK,
    input wire logic RST_B,
    // Register bus.
    input wire logic [dcz_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [dcz_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Control pins.
    input wire logic INTERFACE_SELECT_PIN,
    input wire logic CONTROL_SELECT_N,
    input wire logic CONTROL_SHIFT_CLOCK,
    input wire logic CONTROL_SERIAL_IN,
    // I2C engine side, same clock.
    input wire logic I2C_WR_STROBE,
    input wire logic [dcz_pkg::IDX_W-1:0] I2C_WR_INDEX,
    input wire logic [7:0] I2C_WR_DATA,
    input wire logic [dcz_pkg::IDX_W-1:0] I2C_RD_INDEX,
    output logic [7:0] I2C_RD_DATA,
    // Audio pins.
    input wire logic FRAME_CLOCK,
    input wire logic AUDIO_BIT_CLOCK,
    input wire logic AUDIO_LANE_1,
    input wire logic AUDIO_LANE_2,
    input wire logic AUDIO_LANE_3,
    input wire logic AUDIO_LANE_4,
    // Results.
    output logic ZERO_FLAG_FIRST,
    output logic ZERO_FLAG_SECOND,
    output logic [1:0] OVERSAMPLE_RATE,
    output logic INTERFACE_I2C,
    output logic IRQ
);
    import dcz_pkg::*;
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [15:0][7:0] mode;
        logic [11:0] ratio_count;
        dcz_osr_type osr;
        logic [1:0] zf_prev;
        logic zero_first_out;
        logic zero_second_out;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_enable;
        logic irq_out;
        logic [7:0] i2c_rdata;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dcz_top_type;
    dcz_top_type r_r, r_nxt;
    dcz_word_if word_bus ();
    logic bit_rise;
    logic frame_tick;
    logic left_half;
    logic [7:0] ch_one;
    logic [1:0] group;
    logic invert;
    logic [7:0] mask_first;
    logic [7:0] mask_second;
    logic hit_first;
    logic hit_second;
    logic zf_first;
    logic zf_second;
    logic sel_i2c;
    logic mode_we;
    logic [IDX_W-1:0] mode_idx;
    logic [7:0] mode_data;
    logic idx_defined;
    logic [IRQ_W-1:0] irq_clear;
    logic [IRQ_W-1:0] events;
    logic [31:0] rd_word;
    logic rd_bad;
    logic [ADDR_W-1:0] ar_word;

    function automatic logic ratio_near(input logic [11:0] m, input logic [11:0] ref_v);
        ratio_near = (m + RATIO_TOL >= ref_v) && (m <= ref_v + RATIO_TOL);
    endfunction : ratio_near

    function automatic dcz_osr_type osr_of(input logic [11:0] m);
        osr_of = OSR_NONE;
        if (ratio_near(m, RATIO_1152) || ratio_near(m, RATIO_768) || ratio_near(m, RATIO_512)) begin
            osr_of = OSR_64X;
        end else if (ratio_near(m, RATIO_384) || ratio_near(m, RATIO_256)) begin
            osr_of = OSR_32X;
        end else if (ratio_near(m, RATIO_192) || ratio_near(m, RATIO_128)) begin
            osr_of = OSR_16X;
        end
    endfunction : osr_of

    // Edges are taken between the second and third stages, never from the first.
    assign bit_rise = r_r.s2[PIN_BCK] & ~r_r.s3[PIN_BCK];
    assign frame_tick = r_r.s2[PIN_FRAME] & ~r_r.s3[PIN_FRAME];
    assign left_half = r_r.s2[PIN_FRAME];
    for (genvar k = 0; k < 4; k++) begin : g_lane
        assign ch_one[2*k] = bit_rise & left_half & r_r.s2[PIN_LANE0+k];
        assign ch_one[2*k+1] = bit_rise & ~left_half & r_r.s2[PIN_LANE0+k];
    end
    assign group = r_r.mode[IDX_ZERO_GROUP][ZERO_GROUP_LSB+1:ZERO_GROUP_LSB];
    assign invert = r_r.mode[IDX_POLARITY][POLARITY_BIT];
    assign mask_first = FIRST_MASKS[group];
    assign mask_second = SECOND_MASKS[group];
    assign hit_first = |(ch_one & mask_first);
    assign hit_second = |(ch_one & mask_second);

    assign sel_i2c = r_r.s2[PIN_IFSEL];
    assign mode_we = sel_i2c ? I2C_WR_STROBE : word_bus.valid;
    assign mode_idx = sel_i2c ? I2C_WR_INDEX : word_bus.index;
    assign mode_data = sel_i2c ? I2C_WR_DATA : word_bus.data;
    // Reserved indices are not stored, so a stray write cannot upset the block.
    assign idx_defined = mode_idx[6:4] == 3'h0 && mode_idx[3:0] != IDX_RESERVED_A
        && mode_idx[3:0] != IDX_RESERVED_B && mode_idx[3:0] != IDX_RESERVED_C;
    assign ar_word = {S_AXI_ARADDR[ADDR_W-1:2], 2'h0};

    dcz_serial_rx u_rx (
        .clk(CLK),
        .rst_b(RST_B),
        .enable(~sel_i2c),
        .select_n(r_r.s2[PIN_SELN]),
        .shift_rise(r_r.s2[PIN_SCLK] & ~r_r.s3[PIN_SCLK]),
        .serial_bit(r_r.s2[PIN_SDI]),
        .word(word_bus.rx)
    );

    dcz_zero_run u_run_first (
        .clk(CLK),
        .rst_b(RST_B),
        .frame_tick(frame_tick),
        .hit(hit_first),
        .watch(|mask_first),
        .flag(zf_first)
    );

    dcz_zero_run u_run_second (
        .clk(CLK),
        .rst_b(RST_B),
        .frame_tick(frame_tick),
        .hit(hit_second),
        .watch(|mask_second),
        .flag(zf_second)
    );

    always_comb begin
        r_nxt = r_r;
        irq_clear = '0;
        rd_word = 32'h0000_0000;
        rd_bad = 1'b0;
        r_nxt.s1 = {AUDIO_LANE_4, AUDIO_LANE_3, AUDIO_LANE_2, AUDIO_LANE_1, AUDIO_BIT_CLOCK, FRAME_CLOCK,
                    CONTROL_SERIAL_IN, CONTROL_SHIFT_CLOCK, CONTROL_SELECT_N, INTERFACE_SELECT_PIN};
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        // Ratio: system clocks between frame starts.
        if (frame_tick) begin
            r_nxt.ratio_count = 12'h001;
            r_nxt.osr = osr_of(r_r.ratio_count);
        end else if (r_r.ratio_count != RATIO_COUNT_MAX) begin
            r_nxt.ratio_count = r_r.ratio_count + 12'h001;
        end
        if (mode_we && idx_defined) begin
            r_nxt.mode[mode_idx[3:0]] = mode_data;
        end
        r_nxt.i2c_rdata = (I2C_RD_INDEX[6:4] == 3'h0) ? r_r.mode[I2C_RD_INDEX[3:0]] : 8'h00;
        // The flag drops on the clock edge that ends the cycle in which the one bit is seen, together with the run flag.
        r_nxt.zero_first_out = (zf_first & ~hit_first) ^ invert;
        r_nxt.zero_second_out = (zf_second & ~hit_second) ^ invert;
        r_nxt.zf_prev = {zf_second, zf_first};
        // Register bus write path.
        if (S_AXI_AWVALID && r_r.awready) begin
            r_nxt.aw_got = 1'b1;
            r_nxt.awaddr = {S_AXI_AWADDR[ADDR_W-1:2], 2'h0};
        end
        if (S_AXI_WVALID && r_r.wready) begin
            r_nxt.w_got = 1'b1;
            r_nxt.wdata = S_AXI_WDATA;
            r_nxt.wstrb0 = S_AXI_WSTRB[0];
        end
        if (r_r.aw_got && r_r.w_got && !r_r.bvalid) begin
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = RESP_OKAY;
            if (r_r.awaddr == ADDR_IRQ_CLEAR) begin
                if (r_r.wstrb0) begin
                    irq_clear = r_r.wdata[IRQ_W-1:0];
                end
            end else if (r_r.awaddr == ADDR_IRQ_ENABLE) begin
                if (r_r.wstrb0) begin
                    r_nxt.irq_enable = r_r.wdata[IRQ_W-1:0];
                end
            end else if (r_r.awaddr[7:6] != 2'h0 && r_r.awaddr != ADDR_STATUS
                         && r_r.awaddr != ADDR_IRQ_STATUS) begin
                r_nxt.bresp = RESP_SLVERR;
            end
        end
        if (r_r.bvalid && S_AXI_BREADY) begin
            r_nxt.bvalid = 1'b0;
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got = 1'b0;
        end
        r_nxt.awready = !r_nxt.aw_got && !r_nxt.bvalid;
        r_nxt.wready = !r_nxt.w_got && !r_nxt.bvalid;
        // Register bus read path.
        if (ar_word[7:6] == 2'h0) begin
            rd_word = {24'h00_0000, r_r.mode[ar_word[5:2]]};
        end else begin
            case (ar_word)
                ADDR_STATUS: begin
                    rd_word[ST_OSR_LSB+1:ST_OSR_LSB] = r_r.osr;
                    rd_word[ST_I2C] = sel_i2c;
                    rd_word[ST_ZF_FIRST] = r_r.zf_prev[0];
                    rd_word[ST_ZF_SECOND] = r_r.zf_prev[1];
                end
                ADDR_IRQ_STATUS: rd_word[IRQ_W-1:0] = r_r.irq_status;
                ADDR_IRQ_ENABLE: rd_word[IRQ_W-1:0] = r_r.irq_enable;
                ADDR_IRQ_CLEAR: rd_word = 32'h0000_0000;
                default: rd_bad = 1'b1;
            endcase
        end
        if (S_AXI_ARVALID && r_r.arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rdata = rd_word;
            r_nxt.rresp = rd_bad ? RESP_SLVERR : RESP_OKAY;
        end else if (r_r.rvalid && S_AXI_RREADY) begin
            r_nxt.rvalid = 1'b0;
        end
        r_nxt.arready = !r_nxt.rvalid;
        // Interrupts: a new event beats a clear in the same cycle.
        events = '0;
        events[IRQ_WORD] = mode_we;
        events[IRQ_FRAME_ERR] = word_bus.frame_error & ~sel_i2c;
        events[IRQ_ZERO_FIRST] = zf_first & ~r_r.zf_prev[0];
        events[IRQ_ZERO_SECOND] = zf_second & ~r_r.zf_prev[1];
        events[IRQ_RATIO] = r_nxt.osr != r_r.osr;
        r_nxt.irq_status = (r_r.irq_status & ~irq_clear) | events;
        r_nxt.irq_out = |(r_nxt.irq_status & r_nxt.irq_enable);
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            r_r <= '{s1: PIN_RESET, s2: PIN_RESET, s3: PIN_RESET, mode: {16{MODE_RESET}},
                     ratio_count: 12'h000, osr: OSR_NONE, zf_prev: 2'h0,
                     zero_first_out: 1'b0, zero_second_out: 1'b0,
                     irq_status: IRQ_RESET, irq_enable: IRQ_RESET, irq_out: 1'b0, i2c_rdata: 8'h00,
                     awready: 1'b0, wready: 1'b0, aw_got: 1'b0, w_got: 1'b0, awaddr: 8'h00,
                     wdata: 32'h0000_0000, wstrb0: 1'b0, bvalid: 1'b0, bresp: 2'h0,
                     arready: 1'b0, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: 2'h0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign S_AXI_AWREADY = r_r.awready;
    assign S_AXI_WREADY = r_r.wready;
    assign S_AXI_BVALID = r_r.bvalid;
    assign S_AXI_BRESP = r_r.bresp;
    assign S_AXI_ARREADY = r_r.arready;
    assign S_AXI_RVALID = r_r.rvalid;
    assign S_AXI_RDATA = r_r.rdata;
    assign S_AXI_RRESP = r_r.rresp;
    assign I2C_RD_DATA = r_r.i2c_rdata;
    assign ZERO_FLAG_FIRST = r_r.zero_first_out;
    assign ZERO_FLAG_SECOND = r_r.zero_second_out;
    assign OVERSAMPLE_RATE = r_r.osr;
    assign INTERFACE_I2C = r_r.s2[PIN_IFSEL];
    assign IRQ = r_r.irq_out;
endmodule : dcz_top
`default_nettype wire

//--- hdl/dcz_word_if.sv
/*
 * Carries one received control word from the serial receiver to the top.
 * Assumes both ends run on the system clock.
 */
`default_nettype none
interface dcz_word_if;
    logic valid;
    logic [dcz_pkg::IDX_W-1:0] index;
    logic [7:0] data;
    logic frame_error;
    modport rx (output valid, index, data, frame_error);
    modport top (input valid, index, data, frame_error);
endinterface : dcz_word_if
`default_nettype wire

//--- hdl/dcz_zero_run.sv
/*
 * Counts consecutive all-zero frames for one zero flag.
 * Assumes frame_tick and hit are single-cycle pulses on the system clock.
 */
`default_nettype none
module dcz_zero_run (
    // System.
    input wire logic clk,
    input wire logic rst_b,
    // Events.
    input wire logic frame_tick,
    input wire logic hit,
    input wire logic watch,
    // Result.
    output logic flag
);
    import dcz_pkg::*;
    typedef struct packed {
        logic [10:0] count;
        logic flag;
    } dcz_run_type;
    dcz_run_type r_r, r_nxt;
    always_comb begin
        r_nxt = r_r;
        if (hit || !watch) begin
            // Parked one below zero: the next frame edge only closes the frame that held the one bit.
            r_nxt.count = 11'h7ff;
        end else if (frame_tick && r_r.count != ZERO_RUN_LIMIT) begin
            r_nxt.count = r_r.count + 11'h001;
        end
        r_nxt.flag = watch && !hit && r_nxt.count == ZERO_RUN_LIMIT;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r_r <= '{count: 11'h7ff, flag: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end
    assign flag = r_r.flag;
endmodule : dcz_zero_run
`default_nettype wire
